// ### verilog/aasa_pkg.sv
// Package: constants, register map and types of the alarm sticky alert aggregator
package aasa_pkg;
  // ==========================================================================
  // Sizes
  localparam int NREF = 4;
  localparam int NLOOP = 5;
  localparam int NALARM = 22;
  localparam int NBLK = 9;
  localparam int NGPIO = 4;
  localparam int LOOP_BASE = 12;
  localparam int SYS_LOOP = 4;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LIVE = 8'h04;
  localparam logic [7:0] OFF_STICKY = 8'h08;
  localparam logic [7:0] OFF_ALERT_EN = 8'h0C;
  localparam logic [7:0] OFF_BLK_STICKY = 8'h10;
  localparam logic [7:0] OFF_BLK_ALERT_EN = 8'h14;
  localparam logic [7:0] OFF_LOOP_STATE = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_GPIO0 = 8'h20;
  // ==========================================================================
  // Field positions and reset values
  localparam int CTRL_GEN_BIT = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int GCFG_EN_BIT = 0;
  localparam int GCFG_ALERT_BIT = 1;
  localparam int GCFG_INV_BIT = 2;
  localparam int GCFG_STICKY_BIT = 3;
  localparam int GCFG_SEL_LSB = 8;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [12:0] GCFG_RST = 13'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Timing
  localparam int ALERT_NEG_US = 200;
  localparam int CLK_MHZ = 250;
  localparam int ALERT_NEG_CYC = ALERT_NEG_US * CLK_MHZ;
  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    LST_FREE = 3'h0,
    LST_ACQ = 3'h1,
    LST_LOCKED = 3'h2,
    LST_HOLDOVER = 3'h3
  } aasa_loop_st_t;
  typedef struct packed {
    logic [11:0] ref_alarm;
    logic [14:0] loop_state;
    logic analog_locked;
  } aasa_mon_t;
endpackage

// ### verilog/aasa_top.sv
// Alarm live/sticky tracking, aggregated alert and GPIO alarm outputs
`timescale 1ns/1ns
// Operation
// RULE1: Alert built from sticky flags only
// RULE2: Sources are reference monitors and loops
// RULE3: Holdover live while loop in holdover
// RULE4: Locked live needs loop and analog lock
// RULE5: Sticky sets on either live edge
// RULE6: Live self-clears, sticky holds until cleared
// RULE7: Loop transitions raise sticky; state readable
// RULE8: Each alarm: live, sticky, clear, controls
// RULE9: Alarm drives individual GPIO or alert
// RULE10: Clear any single flag or combination
// RULE11: Per-block sticky, clear, controls, state field
// RULE12: Alert holds until alarm and block cleared
// RULE13: Software clears alarm flags before block
// RULE14: Alert pin may lag clear 200us
// RULE15: Global enable gates all alarm sources
// RULE16: Assign alert GPIO, select contributing alarms
// RULE17: Alert polarity inversion option
// RULE18: Alert is OR of enabled sticky flags
// RULE19: Software writes clear bit to clear
// RULE20: Set wins over simultaneous clear
module aasa_top #(
  parameter int ALERT_HOLD_CYC = aasa_pkg::ALERT_NEG_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire aasa_pkg::aasa_mon_t mon,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic alert_pin,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe
);
  // ==========================================================================
  // Functions
  function automatic aasa_pkg::aasa_loop_st_t loop_st(input logic [14:0] v, input int i);
    return aasa_pkg::aasa_loop_st_t'(v[3*i +: 3]);
  endfunction
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
  // ==========================================================================
  // State
  logic [1:0] ctrl_q;
  logic [21:0] live_c;
  logic [21:0] live_q;
  logic [21:0] sticky_q;
  logic [21:0] alert_en_q;
  logic [8:0] blk_q;
  logic [8:0] blk_en_q;
  logic [8:0] blk_any;
  logic [12:0] gcfg_q [4];
  logic [16:0] hold_q;
  logic alert_raw;
  logic alert_lvl_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic wr_map;
  logic [31:0] wmask;
  logic [31:0] bmask;
  logic [21:0] alarm_clr;
  logic [8:0] blk_clr;
  logic gen;
  assign gen = ctrl_q[aasa_pkg::CTRL_GEN_BIT];
  // ==========================================================================
  // Live alarm levels
  always_comb begin
    live_c = '0;
    live_c[11:0] = mon.ref_alarm; // RULE2
    for (int j = 0; j < aasa_pkg::NLOOP; j++) begin
      live_c[aasa_pkg::LOOP_BASE + 2*j] =
        (loop_st(mon.loop_state, j) == aasa_pkg::LST_HOLDOVER); // RULE3
      live_c[aasa_pkg::LOOP_BASE + 2*j + 1] =
        (loop_st(mon.loop_state, j) == aasa_pkg::LST_LOCKED) && mon.analog_locked; // RULE4
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_q <= '0;
    end else begin
      live_q <= live_c;
    end
  end
  // ==========================================================================
  // Sticky flags
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  // Byte lanes not strobed keep their old bits
  assign bmask = strb_mask(wstrb_q);
  assign wmask = wdata_q & bmask;
  assign alarm_clr = (wr_go && awaddr_q == aasa_pkg::OFF_STICKY) ? wmask[21:0] : '0; // RULE10
  assign blk_clr = (wr_go && awaddr_q == aasa_pkg::OFF_BLK_STICKY) ? wmask[8:0] : '0;
  always_comb begin
    blk_any = '0;
    for (int b = 0; b < aasa_pkg::NREF; b++) begin
      blk_any[b] = |sticky_q[3*b +: 3];
    end
    for (int j = 0; j < aasa_pkg::NLOOP; j++) begin
      blk_any[aasa_pkg::NREF + j] = |sticky_q[aasa_pkg::LOOP_BASE + 2*j +: 2];
    end
  end
  // Disabled sources record no new edge; existing flags remain for service
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sticky_q <= '0;
    end else begin
      sticky_q <= (sticky_q & ~alarm_clr) | ((live_c ^ live_q) & {22{gen}}); // RULE5 RULE6 RULE7 RULE15 RULE20
    end
  end
  // Still-set alarm flags re-raise the block flag after a block clear while the global enable is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_q <= '0;
    end else begin
      blk_q <= (blk_q & ~blk_clr) | (blk_any & {9{gen}}); // RULE11 RULE12 RULE13 RULE20
    end
  end
  // ==========================================================================
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= aasa_pkg::CTRL_RST;
      alert_en_q <= '0;
      blk_en_q <= '0;
    end else if (wr_go) begin
      unique case (awaddr_q)
        aasa_pkg::OFF_CTRL: ctrl_q <= (ctrl_q & ~bmask[1:0]) | wmask[1:0]; // RULE15
        aasa_pkg::OFF_ALERT_EN: alert_en_q <= (alert_en_q & ~bmask[21:0]) | wmask[21:0]; // RULE16
        aasa_pkg::OFF_BLK_ALERT_EN: blk_en_q <= (blk_en_q & ~bmask[8:0]) | wmask[8:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    for (int g = 0; g < aasa_pkg::NGPIO; g++) begin
      if (!aresetn) begin
        gcfg_q[g] <= aasa_pkg::GCFG_RST;
      end else if (wr_go && awaddr_q == aasa_pkg::OFF_GPIO0 + 8'(4*g)) begin
        gcfg_q[g] <= (gcfg_q[g] & ~bmask[12:0]) | wmask[12:0];
      end
    end
  end

  // ==========================================================================
  // Aggregated alert
  assign alert_raw = |(sticky_q & alert_en_q) || |(blk_q & blk_en_q); // RULE1 RULE18 RULE12
  // Negation is stretched so a clear never produces a glitch burst on the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= '0;
      alert_lvl_q <= 1'b0;
    end else if (alert_raw) begin
      hold_q <= 17'(ALERT_HOLD_CYC - 1);
      alert_lvl_q <= 1'b1;
    end else if (hold_q != 17'h00000) begin
      hold_q <= hold_q - 17'h00001; // RULE14
    end else begin
      alert_lvl_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_pin <= 1'b0;
    end else begin
      alert_pin <= alert_lvl_q ^ ctrl_q[aasa_pkg::CTRL_INV_BIT]; // RULE17
    end
  end

  // ==========================================================================
  // GPIO alarm outputs
  always_ff @(posedge aclk) begin
    for (int g = 0; g < aasa_pkg::NGPIO; g++) begin
      if (!aresetn) begin
        gpio_out[g] <= 1'b0;
        gpio_oe[g] <= 1'b0;
      end else begin
        logic [4:0] sel;
        logic val;
        sel = gcfg_q[g][aasa_pkg::GCFG_SEL_LSB +: 5];
        val = 1'b0;
        if (gcfg_q[g][aasa_pkg::GCFG_ALERT_BIT]) begin
          val = alert_lvl_q; // RULE9 RULE16
        end else if (int'(sel) < aasa_pkg::NALARM) begin
          val = gcfg_q[g][aasa_pkg::GCFG_STICKY_BIT] ? sticky_q[sel] : live_q[sel]; // RULE9
        end
        gpio_out[g] <= val ^ gcfg_q[g][aasa_pkg::GCFG_INV_BIT];
        gpio_oe[g] <= gcfg_q[g][aasa_pkg::GCFG_EN_BIT];
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  always_comb begin
    wr_map = (awaddr_q == aasa_pkg::OFF_CTRL) || (awaddr_q == aasa_pkg::OFF_STICKY) ||
      (awaddr_q == aasa_pkg::OFF_ALERT_EN) || (awaddr_q == aasa_pkg::OFF_BLK_STICKY) ||
      (awaddr_q == aasa_pkg::OFF_BLK_ALERT_EN) ||
      (awaddr_q >= aasa_pkg::OFF_GPIO0 && awaddr_q < aasa_pkg::OFF_GPIO0 + 8'h10 &&
       awaddr_q[1:0] == 2'h0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aasa_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? aasa_pkg::RESP_OKAY : aasa_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= aasa_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= aasa_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
      unique case (s_axi_araddr)
        aasa_pkg::OFF_CTRL: s_axi_rdata <= {30'h0, ctrl_q};
        aasa_pkg::OFF_LIVE: s_axi_rdata <= {10'h0, live_q}; // RULE8
        aasa_pkg::OFF_STICKY: s_axi_rdata <= {10'h0, sticky_q};
        aasa_pkg::OFF_ALERT_EN: s_axi_rdata <= {10'h0, alert_en_q};
        aasa_pkg::OFF_BLK_STICKY: s_axi_rdata <= {23'h0, blk_q};
        aasa_pkg::OFF_BLK_ALERT_EN: s_axi_rdata <= {23'h0, blk_en_q};
        aasa_pkg::OFF_LOOP_STATE: s_axi_rdata <= {17'h0, mon.loop_state}; // RULE7 RULE11
        aasa_pkg::OFF_STATUS: s_axi_rdata <= {30'h0, alert_lvl_q, alert_raw};
        aasa_pkg::OFF_GPIO0: s_axi_rdata <= {19'h0, gcfg_q[0]};
        aasa_pkg::OFF_GPIO0 + 8'h04: s_axi_rdata <= {19'h0, gcfg_q[1]};
        aasa_pkg::OFF_GPIO0 + 8'h08: s_axi_rdata <= {19'h0, gcfg_q[2]};
        aasa_pkg::OFF_GPIO0 + 8'h0C: s_axi_rdata <= {19'h0, gcfg_q[3]};
        default: s_axi_rresp <= aasa_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_sticky_edge;
    gen && (live_c != live_q) |=> ((sticky_q & $past(live_c ^ live_q)) == $past(live_c ^ live_q));
  endproperty
  a_sticky_edge: assert property (p_sticky_edge) else $error("sticky missed live edge"); // RULE5 RULE20
  property p_sticky_hold;
    sticky_q[0] && !alarm_clr[0] |=> sticky_q[0];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky dropped uncleared"); // RULE6
  property p_holdover_live;
    loop_st(mon.loop_state, aasa_pkg::SYS_LOOP) == aasa_pkg::LST_HOLDOVER |=> live_q[20];
  endproperty
  a_holdover_live: assert property (p_holdover_live) else $error("holdover live low"); // RULE3
  property p_lock_needs_analog;
    !mon.analog_locked |=> !live_q[13] && !live_q[21];
  endproperty
  a_lock_needs_analog: assert property (p_lock_needs_analog) else $error("locked without analog"); // RULE4
  property p_no_sticky_no_alert;
    sticky_q == '0 && blk_q == '0 |-> !alert_raw;
  endproperty
  a_no_sticky_no_alert: assert property (p_no_sticky_no_alert) else $error("alert w/o sticky"); // RULE1
  property p_block_follows;
    gen && (|sticky_q[2:0]) |=> blk_q[0];
  endproperty
  a_block_follows: assert property (p_block_follows) else $error("block flag not raised"); // RULE12
  property p_disabled_quiet;
    !gen && sticky_q == '0 |=> sticky_q == '0;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("sticky set while disabled"); // RULE15
  property p_pin_polarity;
    alert_raw |=> ##1 alert_pin == !$past(ctrl_q[aasa_pkg::CTRL_INV_BIT]);
  endproperty
  a_pin_polarity: assert property (p_pin_polarity) else $error("alert pin level wrong"); // RULE17
  property p_release;
    !alert_raw && hold_q == 17'h00000 |=> !alert_lvl_q;
  endproperty
  a_release: assert property (p_release) else $error("alert held past window"); // RULE14
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
  c_alert: cover property (alert_raw ##1 alert_lvl_q);
  c_clear: cover property (sticky_q != '0 ##1 sticky_q == '0);
  c_gpio: cover property (gpio_oe[0] && gpio_out[0]);
endmodule // aasa_top

// ### bench/aasa_host.sv
// Host model: alarm-servicing software reaching the registers over AXI4-Lite
`timescale 1ns/1ns
module aasa_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ========
  // Clears are plain register writes, one word each
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dat = s_axi_rdata;
        resp = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule // aasa_host

// ### bench/tb_top.sv
// Testbench: live/sticky alarm model against the aggregator, with host model
`timescale 1ns/1ns
module tb_top;
  logic aclk, aresetn, alert_pin;
  aasa_pkg::aasa_mon_t mon;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, gpio_out, gpio_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int bad_count = 0;
  int tests_run = 0;
  logic [21:0] exp_live, exp_sticky;

  // Short hold keeps the pin release visible within a few cycles
  aasa_top #(.ALERT_HOLD_CYC(8)) aasa_top_i (.*);
  aasa_host aasa_host_i (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ========
  // Model and compares
  function automatic logic [21:0] live_of(aasa_pkg::aasa_mon_t m);
    logic [21:0] l;
    l[11:0] = m.ref_alarm;
    for (int j = 0; j < 5; j++) begin
      l[12 + 2 * j] = (m.loop_state[3 * j +: 3] == 3'h3);
      l[13 + 2 * j] = (m.loop_state[3 * j +: 3] == 3'h2) && m.analog_locked;
    end
    return l;
  endfunction
  // Block flag: any alarm sticky of that block
  function automatic logic [8:0] blk_of(input logic [21:0] s);
    logic [8:0] b;
    for (int i = 0; i < 4; i++) b[i] = |s[3 * i +: 3];
    for (int j = 0; j < 5; j++) b[4 + j] = |s[12 + 2 * j +: 2];
    return b;
  endfunction
  task automatic fail(input string what);
    bad_count++;
    $display("CHECK FAILED t=%0t %s", $time, what);
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("rdata %h exp %h", got, exp));
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("resp %h exp %h", got, exp));
  endtask
  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("pins %b exp %b", got, exp));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] dat;
    logic [1:0] resp;
    aasa_host_i.rd(a, dat, resp);
    chk_val(dat, e);
    chk_resp(resp, er);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic [1:0] resp;
    aasa_host_i.wr(a, dat, resp);
    chk_resp(resp, er);
  endtask
  // New random monitor inputs; sticky model only accumulates while enabled
  task automatic step(input logic en);
    aasa_pkg::aasa_mon_t m;
    m.ref_alarm = 12'($urandom);
    m.analog_locked = 1'($urandom);
    for (int j = 0; j < 5; j++) m.loop_state[3 * j +: 3] = 3'($urandom % 4);
    @(posedge aclk);
    mon <= m;
    if (en) exp_sticky |= exp_live ^ live_of(m);
    exp_live = live_of(m);
    repeat (3) @(posedge aclk);
  endtask
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail("timeout");
    end_sim();
  end
  // ========
  // Main sequence
  initial begin
    mon = '0;
    aresetn = 1'b0;
    exp_live = '0;
    exp_sticky = '0;
    void'($urandom(49862));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(aasa_pkg::OFF_CTRL, 32'h0, aasa_pkg::RESP_OKAY);
    rd_chk(aasa_pkg::OFF_STICKY, 32'h0, aasa_pkg::RESP_OKAY);
    rd_chk(aasa_pkg::OFF_GPIO0, 32'h0, aasa_pkg::RESP_OKAY);
    rd_chk(8'h40, 32'h0, aasa_pkg::RESP_SLVERR);
    wr_chk(8'h40, 32'hFFFF_FFFF, aasa_pkg::RESP_SLVERR);
    chk_pin({1'b0, alert_pin}, 2'b00);
    chk_pin({gpio_oe[3], gpio_out[3]}, 2'b00);
    $display("reset test done");
    wr_chk(aasa_pkg::OFF_CTRL, 32'h1, aasa_pkg::RESP_OKAY);
    wr_chk(aasa_pkg::OFF_ALERT_EN, 32'h003F_FFFF, aasa_pkg::RESP_OKAY);
    wr_chk(aasa_pkg::OFF_BLK_ALERT_EN, 32'h0000_01FF, aasa_pkg::RESP_OKAY);
    wr_chk(aasa_pkg::OFF_GPIO0, 32'h0000_0C01, aasa_pkg::RESP_OKAY);
    wr_chk(aasa_pkg::OFF_GPIO0 + 8'h04, 32'h0000_0003, aasa_pkg::RESP_OKAY);
    wr_chk(aasa_pkg::OFF_GPIO0 + 8'h08, 32'h0000_000D, aasa_pkg::RESP_OKAY);
    for (int i = 0; i < 24; i++) begin
      step(1'b1);
      rd_chk(aasa_pkg::OFF_LIVE, {10'h0, exp_live}, aasa_pkg::RESP_OKAY);
      rd_chk(aasa_pkg::OFF_STICKY, {10'h0, exp_sticky}, aasa_pkg::RESP_OKAY);
      rd_chk(aasa_pkg::OFF_LOOP_STATE, {17'h0, mon.loop_state}, aasa_pkg::RESP_OKAY);
      chk_pin({gpio_oe[0], gpio_out[0]}, {1'b1, exp_live[12]});
      chk_pin({1'b0, alert_pin}, {1'b0, |exp_sticky});
      chk_pin({gpio_oe[1], gpio_out[1]}, {1'b1, |exp_sticky});
      chk_pin({gpio_oe[2], gpio_out[2]}, {1'b1, ~exp_sticky[0]});
    end
    rd_chk(aasa_pkg::OFF_BLK_STICKY, {23'h0, blk_of(exp_sticky)}, aasa_pkg::RESP_OKAY);
    rd_chk(aasa_pkg::OFF_STATUS, {30'h0, {2{|exp_sticky}}}, aasa_pkg::RESP_OKAY);
    $display("live and sticky test done");
    wr_chk(aasa_pkg::OFF_STICKY, {10'h0, exp_sticky & 22'h0F0F0F}, aasa_pkg::RESP_OKAY);
    exp_sticky &= ~22'h0F0F0F;
    rd_chk(aasa_pkg::OFF_STICKY, {10'h0, exp_sticky}, aasa_pkg::RESP_OKAY);
    // Alarm flags first so the block flags cannot come back
    wr_chk(aasa_pkg::OFF_STICKY, 32'h003F_FFFF, aasa_pkg::RESP_OKAY);
    exp_sticky = '0;
    repeat (20) @(posedge aclk);
    chk_pin({1'b0, alert_pin}, 2'b01);
    wr_chk(aasa_pkg::OFF_BLK_STICKY, 32'h0000_01FF, aasa_pkg::RESP_OKAY);
    chk_pin({1'b0, alert_pin}, 2'b01);
    repeat (20) @(posedge aclk);
    chk_pin({1'b0, alert_pin}, 2'b00);
    rd_chk(aasa_pkg::OFF_BLK_STICKY, 32'h0, aasa_pkg::RESP_OKAY);
    $display("clear test done");
    wr_chk(aasa_pkg::OFF_CTRL, 32'h0, aasa_pkg::RESP_OKAY);
    step(1'b0);
    rd_chk(aasa_pkg::OFF_LIVE, {10'h0, exp_live}, aasa_pkg::RESP_OKAY);
    rd_chk(aasa_pkg::OFF_STICKY, 32'h0, aasa_pkg::RESP_OKAY);
    chk_pin({1'b0, alert_pin}, 2'b00);
    wr_chk(aasa_pkg::OFF_CTRL, 32'h2, aasa_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk_pin({1'b0, alert_pin}, 2'b01);
    wr_chk(aasa_pkg::OFF_CTRL, 32'h3, aasa_pkg::RESP_OKAY);
    step(1'b1);
    rd_chk(aasa_pkg::OFF_STICKY, {10'h0, exp_sticky}, aasa_pkg::RESP_OKAY);
    chk_pin({1'b0, alert_pin}, {1'b0, ~|exp_sticky});
    $display("enable and polarity test done");
    end_sim();
  end
endmodule // tb_top
